//--- rtl/adcs_defines.svh
`ifndef ADCS_DEFINES_SVH
`define ADCS_DEFINES_SVH
// Register byte offsets
`define ADCS_OFS_CTRL    5'h00
`define ADCS_OFS_TRIG    5'h04
`define ADCS_OFS_CFG     5'h08
`define ADCS_OFS_RESH    5'h0C
`define ADCS_OFS_RESL    5'h10
`define ADCS_OFS_CMPH    5'h14
`define ADCS_OFS_CMPL    5'h18
// Control register fields
`define ADCS_CTRL_FLAG   7
`define ADCS_CTRL_IRQEN  6
`define ADCS_CTRL_CONT   5
`define ADCS_CH_OFF      5'h1F
// Trigger register fields
`define ADCS_TRIG_ACT    7
`define ADCS_TRIG_HWT    6
`define ADCS_TRIG_CMPEN  5
`define ADCS_TRIG_CMPGT  4
// Configuration register fields
`define ADCS_CFG_LONG    4
`define ADCS_CLK_ASYNC   2'h3
`define ADCS_MODE_8      2'h0
`define ADCS_MODE_12     2'h1
`define ADCS_MODE_10     2'h2
// Reset values
`define ADCS_CTRL_RST    8'h1F
`define ADCS_BYTE_RST    8'h00
// Timing
`define ADCS_CLK_PERIOD_NS   20
`define ADCS_ASYNC_START_NS  5000
`define ADCS_ASYNC_START_CYC (`ADCS_ASYNC_START_NS / `ADCS_CLK_PERIOD_NS)
`define ADCS_SHORT_SAMP_X10  35
`define ADCS_LONG_SAMP_X10   235
`define ADCS_SHORT_SAMP_CYC  ((`ADCS_SHORT_SAMP_X10 + 9) / 10)
`define ADCS_LONG_SAMP_CYC   ((`ADCS_LONG_SAMP_X10 + 9) / 10)
`define ADCS_FIRST_S8        20
`define ADCS_FIRST_S12       23
`define ADCS_FIRST_L8        40
`define ADCS_FIRST_L12       43
`define ADCS_NEXT_S8         17
`define ADCS_NEXT_S12        20
`define ADCS_NEXT_L8         37
`define ADCS_NEXT_L12        40
`define ADCS_BUS_OVERHEAD    5
`endif

//--- rtl/adcs_pkg.sv
package adcs_pkg;
	typedef enum logic [4:0] {
		ST_IDLE    = 5'h01,
		ST_WARM    = 5'h02,
		ST_SAMPLE  = 5'h04,
		ST_CONVERT = 5'h08,
		ST_XFER    = 5'h10
	} adcs_state_t;
	typedef logic [11:0] adcs_code_t;
endpackage

//--- rtl/adcs_core_if.sv
`timescale 1ns/100ps
interface adcs_core_if;
	logic               tick;
	logic               osc_ready;
	logic [1:0]         clk_sel;
	logic [1:0]         div_sel;
	logic               run;
	logic               sar_start;
	logic [3:0]         sar_nbits;
	logic               sar_done;
	adcs_pkg::adcs_code_t sar_code;
	logic               comp_above;
	modport clkgen (input clk_sel, div_sel, run, output tick, osc_ready);
	modport sar (input tick, sar_start, sar_nbits, comp_above, output sar_done, sar_code);
	modport seq (
		output clk_sel, div_sel, run, sar_start, sar_nbits, comp_above,
		input  tick, osc_ready, sar_done, sar_code
	);
endinterface

//--- rtl/adcs_clkgen.sv
`timescale 1ns/100ps
`include "adcs_defines.svh"
module adcs_clkgen (
	input  wire logic i_clock,    // Bus clock
	input  wire logic i_rst,      // Sync reset
	input  wire logic i_alt_tick, // Alternate clock enable
	adcs_core_if.clkgen cif       // Tick side
);
	logic       half_r;
	logic       osc_r;
	logic [8:0] warm_r;
	logic [2:0] div_cnt_r;
	logic       src;
	logic       async_sel;

	assign async_sel = cif.clk_sel == `ADCS_CLK_ASYNC;
	assign cif.osc_ready = warm_r == 9'(`ADCS_ASYNC_START_CYC);

	always_comb begin
		case (cif.clk_sel)
			2'h0: src = 1'b1;
			2'h1: src = half_r;
			2'h2: src = i_alt_tick;
			default: src = osc_r & cif.osc_ready;
		endcase
	end

	// Oscillator start-up delay, then free running at half rate
	always_ff @(posedge i_clock) begin
		if (i_rst || !cif.run || !async_sel) begin
			warm_r <= 9'h000;
			osc_r  <= 1'b0;
		end else begin
			if (!cif.osc_ready)
				warm_r <= warm_r + 9'h001;
			osc_r <= ~osc_r;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_rst || !cif.run) begin
			half_r    <= 1'b0;
			div_cnt_r <= 3'h0;
			cif.tick  <= 1'b0;
		end else begin
			half_r   <= ~half_r;
			cif.tick <= src && div_cnt_r == 3'((4'h1 << cif.div_sel) - 4'h1);
			if (src)
				div_cnt_r <= (div_cnt_r == 3'((4'h1 << cif.div_sel) - 4'h1)) ?
					3'h0 : div_cnt_r + 3'h1;
		end
	end
endmodule

//--- rtl/adcs_sar.sv
`timescale 1ns/100ps
module adcs_sar (
	input  wire logic i_clock, // Bus clock
	input  wire logic i_rst,   // Sync reset
	adcs_core_if.sar  cif      // Step side
);
	logic [11:0] bit_r;
	logic [3:0]  left_r;

	// One approximation step per conversion-clock tick
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			cif.sar_code <= 12'h000;
			bit_r        <= 12'h000;
			left_r       <= 4'h0;
			cif.sar_done <= 1'b0;
		end else begin
			cif.sar_done <= 1'b0;
			if (cif.sar_start) begin
				cif.sar_code <= 12'h800;
				bit_r        <= 12'h800;
				left_r       <= cif.sar_nbits;
			end else if (cif.tick && left_r != 4'h0) begin
				cif.sar_code <= (cif.comp_above ? cif.sar_code : cif.sar_code & ~bit_r)
					| (bit_r >> 1);
				bit_r        <= bit_r >> 1;
				left_r       <= left_r - 4'h1;
				cif.sar_done <= left_r == 4'h1;
			end
		end
	end
endmodule

//--- rtl/adcs_seq.sv
`timescale 1ns/100ps
`include "adcs_defines.svh"
module adcs_seq (
	input  wire logic        i_clock,           // Bus clock, 50 MHz
	input  wire logic        i_rst,             // Sync reset, active high
	input  wire logic [4:0]  i_avs_address,     // Byte address
	input  wire logic        i_avs_read,        // Read request
	input  wire logic        i_avs_write,       // Write request
	input  wire logic [31:0] i_avs_writedata,   // Write data
	input  wire logic [3:0]  i_avs_byteenable,  // Byte lanes
	output logic [31:0]      o_avs_readdata,    // Read data
	output logic             o_avs_waitrequest, // Stall
	input  wire logic        i_hardware_trigger_input, // Start trigger
	input  wire logic        i_alt_tick,        // Alternate clock enable
	input  wire logic        i_wait_mode,       // Processor in wait
	input  wire logic        i_stop3_mode,      // Processor in stop3
	input  wire logic        i_stop12_mode,     // Processor in stop1/stop2
	input  wire logic        i_comp_above,      // Input above trial code
	output logic             o_sample_en,       // Sampling switch closed
	output logic [4:0]       o_channel,         // Selected channel
	output logic [11:0]      o_trial_code,      // Approximation code
	output logic             o_irq,             // Conversion interrupt
	output logic             o_wake             // Low-power wake request
);
	adcs_core_if cif ();

	adcs_pkg::adcs_state_t state_r;
	logic [7:0]  ctrl_r;
	logic [7:0]  trig_r;
	logic [7:0]  cfg_r;
	logic [7:0]  cmph_r;
	logic [7:0]  cmpl_r;
	logic [11:0] res_r;
	logic        flag_r;
	logic        half_read_r;
	logic        ack_r;
	logic        hw_prev_r;
	logic        sar_start_r;
	logic [4:0]  samp_cnt_r;
	logic        first_r;
	logic [31:0] rdata_r;
	logic        rst_all;
	logic        acc_wr;
	logic        acc_rd;
	logic        lane0;
	logic        wr_ctrl;
	logic        cfg_wr;
	logic        abort;
	logic        sw_start;
	logic        hw_start;
	logic        hw_edge;
	logic        stop_kill;
	logic        cmp_en;
	logic        cmp_ok;
	logic        blocked;
	logic [4:0]  samp_last;
	logic [11:0] raw;
	logic [11:0] cmp_val;
	logic [11:0] diff;

	////////////////////////////////////////////////////////////////////////////
	// Helpers

	// Round raw approximation code to the selected resolution
	function automatic logic [11:0] adcs_round(input logic [1:0] mode, input logic [11:0] c);
		logic [11:0] r;
		r = 12'h000;
		case (mode)
			`ADCS_MODE_8:
				r = (c[11:4] == 8'hFF) ? 12'h0FF : {4'h0, c[11:4] + {7'h00, c[3]}};
			`ADCS_MODE_10:
				r = (c[11:2] == 10'h3FF) ? 12'h3FF : {2'h0, c[11:2] + {9'h000, c[1]}};
			default:
				r = c;
		endcase
		return r;
	endfunction

	function automatic logic [11:0] adcs_mask(input logic [1:0] mode, input logic [11:0] v);
		logic [11:0] r;
		r = v;
		case (mode)
			`ADCS_MODE_8:  r = {4'h0, v[7:0]};
			`ADCS_MODE_10: r = {2'h0, v[9:0]};
			default:       r = v;
		endcase
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Bus slave: one wait state on every access

	assign rst_all           = i_rst | i_stop12_mode;
	assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_r;
	assign acc_wr            = i_avs_write & ack_r;
	assign acc_rd            = i_avs_read & ack_r;
	assign lane0             = i_avs_byteenable[0];
	assign o_avs_readdata    = rdata_r;

	always_ff @(posedge i_clock) begin
		if (rst_all)
			ack_r <= 1'b0;
		else
			ack_r <= (i_avs_read | i_avs_write) & ~ack_r;
	end

	always_ff @(posedge i_clock) begin
		if (rst_all) begin
			rdata_r <= 32'h00000000;
		end else if (i_avs_read && !ack_r) begin
			case (i_avs_address)
				`ADCS_OFS_CTRL: rdata_r <= {24'h000000, flag_r, ctrl_r[6:0]};
				`ADCS_OFS_TRIG: rdata_r <= {24'h000000, state_r != adcs_pkg::ST_IDLE,
					trig_r[6:4], 4'h0};
				`ADCS_OFS_CFG:  rdata_r <= {24'h000000, cfg_r};
				`ADCS_OFS_RESH: rdata_r <= {28'h0000000, res_r[11:8]};
				`ADCS_OFS_RESL: rdata_r <= {24'h000000, res_r[7:0]};
				`ADCS_OFS_CMPH: rdata_r <= {24'h000000, cmph_r};
				`ADCS_OFS_CMPL: rdata_r <= {24'h000000, cmpl_r};
				default:        rdata_r <= 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge i_clock) begin
		if (rst_all) begin
			ctrl_r <= `ADCS_CTRL_RST;
			trig_r <= `ADCS_BYTE_RST;
			cfg_r  <= `ADCS_BYTE_RST;
			cmph_r <= `ADCS_BYTE_RST;
			cmpl_r <= `ADCS_BYTE_RST;
		end else if (acc_wr && lane0) begin
			case (i_avs_address)
				`ADCS_OFS_CTRL: ctrl_r <= {1'b0, i_avs_writedata[6:0]};
				`ADCS_OFS_TRIG: trig_r <= {1'b0, i_avs_writedata[6:4], 4'h0};
				`ADCS_OFS_CFG:  cfg_r  <= i_avs_writedata[7:0];
				`ADCS_OFS_CMPH: cmph_r <= {4'h0, i_avs_writedata[3:0]};
				`ADCS_OFS_CMPL: cmpl_r <= i_avs_writedata[7:0];
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Start and abort decisions

	assign wr_ctrl  = acc_wr && lane0 && i_avs_address == `ADCS_OFS_CTRL;
	assign cfg_wr   = acc_wr && lane0 && (i_avs_address == `ADCS_OFS_TRIG
		|| i_avs_address == `ADCS_OFS_CFG || i_avs_address == `ADCS_OFS_CMPH
		|| i_avs_address == `ADCS_OFS_CMPL);
	assign stop_kill = i_stop3_mode && cfg_r[1:0] != `ADCS_CLK_ASYNC;
	assign abort    = wr_ctrl | cfg_wr | stop_kill | i_stop12_mode;
	assign sw_start = wr_ctrl && i_avs_writedata[4:0] != `ADCS_CH_OFF
		&& !trig_r[`ADCS_TRIG_HWT] && !stop_kill;
	assign hw_edge  = i_hardware_trigger_input & ~hw_prev_r;
	// Wait mode and async stop3 leave triggering untouched
	assign hw_start = trig_r[`ADCS_TRIG_HWT] && hw_edge && state_r == adcs_pkg::ST_IDLE
		&& ctrl_r[4:0] != `ADCS_CH_OFF && !abort;

	always_ff @(posedge i_clock) begin
		if (rst_all)
			hw_prev_r <= 1'b0;
		else
			hw_prev_r <= i_hardware_trigger_input;
	end

	////////////////////////////////////////////////////////////////////////////
	// Compare and transfer arithmetic

	assign raw     = adcs_round(cfg_r[3:2], cif.sar_code);
	assign cmp_val = adcs_mask(cfg_r[3:2], {cmph_r[3:0], cmpl_r});
	assign diff    = raw + (~cmp_val + 12'h001);
	assign cmp_en  = trig_r[`ADCS_TRIG_CMPEN];
	assign cmp_ok  = trig_r[`ADCS_TRIG_CMPGT] ? (raw >= cmp_val) : (raw < cmp_val);
	assign blocked = half_read_r && cfg_r[3:2] != `ADCS_MODE_8;
	assign samp_last = cfg_r[`ADCS_CFG_LONG] ? 5'(`ADCS_LONG_SAMP_CYC - 1)
		: 5'(`ADCS_SHORT_SAMP_CYC - 1);

	////////////////////////////////////////////////////////////////////////////
	// Sequencer

	always_ff @(posedge i_clock) begin
		if (rst_all) begin
			state_r     <= adcs_pkg::ST_IDLE;
			samp_cnt_r  <= 5'h00;
			sar_start_r <= 1'b0;
			first_r     <= 1'b1;
		end else begin
			sar_start_r <= 1'b0;
			if (abort) begin
				state_r <= sw_start ? adcs_pkg::ST_WARM : adcs_pkg::ST_IDLE;
				first_r <= 1'b1;
			end else begin
				case (state_r)
					adcs_pkg::ST_IDLE: begin
						if (hw_start) begin
							state_r <= adcs_pkg::ST_WARM;
							first_r <= 1'b1;
						end
					end
					adcs_pkg::ST_WARM: begin
						samp_cnt_r <= 5'h00;
						if (cfg_r[1:0] != `ADCS_CLK_ASYNC || cif.osc_ready)
							state_r <= adcs_pkg::ST_SAMPLE;
					end
					adcs_pkg::ST_SAMPLE: begin
						// Sample window counted in conversion ticks only
						if (cif.tick) begin
							samp_cnt_r <= samp_cnt_r + 5'h01;
							if (samp_cnt_r == samp_last) begin
								state_r     <= adcs_pkg::ST_CONVERT;
								sar_start_r <= 1'b1;
							end
						end
					end
					adcs_pkg::ST_CONVERT: begin
						if (cif.sar_done)
							state_r <= adcs_pkg::ST_XFER;
					end
					adcs_pkg::ST_XFER: begin
						samp_cnt_r <= 5'h00;
						first_r    <= 1'b0;
						if (cmp_en && !cmp_ok)
							state_r <= ctrl_r[`ADCS_CTRL_CONT] ? adcs_pkg::ST_SAMPLE
								: adcs_pkg::ST_IDLE;
						else if (blocked || ctrl_r[`ADCS_CTRL_CONT])
							state_r <= adcs_pkg::ST_SAMPLE;
						else
							state_r <= adcs_pkg::ST_IDLE;
					end
					default: state_r <= adcs_pkg::ST_IDLE;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Result, flag and half-read tracking

	always_ff @(posedge i_clock) begin
		if (rst_all) begin
			res_r <= 12'h000;
		end else if (state_r == adcs_pkg::ST_XFER && !abort && !blocked
				&& (!cmp_en || cmp_ok)) begin
			res_r <= cmp_en ? adcs_mask(cfg_r[3:2], diff) : raw;
		end
	end

	// Setting wins over a clear in the same cycle
	always_ff @(posedge i_clock) begin
		if (rst_all)
			flag_r <= 1'b0;
		else if (state_r == adcs_pkg::ST_XFER && !abort && !blocked
				&& (!cmp_en || cmp_ok))
			flag_r <= 1'b1;
		else if (wr_ctrl || (acc_rd && i_avs_address == `ADCS_OFS_RESL))
			flag_r <= 1'b0;
	end

	always_ff @(posedge i_clock) begin
		if (rst_all)
			half_read_r <= 1'b0;
		else if (acc_rd && i_avs_address == `ADCS_OFS_RESH)
			half_read_r <= 1'b1;
		else if (acc_rd && i_avs_address == `ADCS_OFS_RESL)
			half_read_r <= 1'b0;
	end

	assign o_irq  = flag_r & ctrl_r[`ADCS_CTRL_IRQEN];
	assign o_wake = o_irq & (i_wait_mode | i_stop3_mode);

	////////////////////////////////////////////////////////////////////////////
	// Clock generator, approximation engine and analog side

	assign cif.clk_sel    = cfg_r[1:0];
	assign cif.div_sel    = cfg_r[6:5];
	assign cif.run        = state_r != adcs_pkg::ST_IDLE;
	assign cif.sar_start  = sar_start_r;
	assign cif.sar_nbits  = (cfg_r[3:2] == `ADCS_MODE_8) ? 4'h9 : 4'hC;
	assign cif.comp_above = i_comp_above;
	assign o_sample_en    = state_r == adcs_pkg::ST_SAMPLE;
	assign o_channel      = ctrl_r[4:0];
	assign o_trial_code   = cif.sar_code;

	adcs_clkgen u_clkgen (
		.i_clock    (i_clock),
		.i_rst      (rst_all),
		.i_alt_tick (i_alt_tick),
		.cif        (cif)
	);

	adcs_sar u_sar (
		.i_clock (i_clock),
		.i_rst   (rst_all),
		.cif     (cif)
	);

	////////////////////////////////////////////////////////////////////////////
	// Checks

	logic [6:0] conv_ticks_r;
	logic [6:0] tick_limit;

	always_comb begin
		case ({first_r, cfg_r[`ADCS_CFG_LONG], cfg_r[3:2] == `ADCS_MODE_8})
			3'h7: tick_limit = 7'(`ADCS_FIRST_L8);
			3'h6: tick_limit = 7'(`ADCS_FIRST_L12);
			3'h5: tick_limit = 7'(`ADCS_FIRST_S8);
			3'h4: tick_limit = 7'(`ADCS_FIRST_S12);
			3'h3: tick_limit = 7'(`ADCS_NEXT_L8);
			3'h2: tick_limit = 7'(`ADCS_NEXT_L12);
			3'h1: tick_limit = 7'(`ADCS_NEXT_S8);
			default: tick_limit = 7'(`ADCS_NEXT_S12);
		endcase
	end

	always_ff @(posedge i_clock) begin
		if (rst_all || state_r == adcs_pkg::ST_XFER || state_r == adcs_pkg::ST_IDLE)
			conv_ticks_r <= 7'h00;
		else if (cif.tick && conv_ticks_r != 7'h7F)
			conv_ticks_r <= conv_ticks_r + 7'h01;
	end

	default clocking cb @(posedge i_clock); endclocking
	default disable iff (rst_all);

	sequence s_good_xfer;
		state_r == adcs_pkg::ST_XFER && !abort && !blocked && (!cmp_en || cmp_ok);
	endsequence

	sequence s_flag_raised;
		flag_r ##0 res_r == $past(cmp_en ? adcs_mask(cfg_r[3:2], diff) : raw);
	endsequence

	chk_conv_tick_budget: assert property (
		state_r == adcs_pkg::ST_XFER |-> conv_ticks_r <= tick_limit
	) else $error("conversion took too many conversion ticks");

	chk_sample_window: assert property (
		state_r == adcs_pkg::ST_SAMPLE && cif.tick && samp_cnt_r == samp_last && !abort
		|=> state_r == adcs_pkg::ST_CONVERT ##1 cif.sar_code == 12'h800
	) else $error("sample window length wrong");

	chk_xfer_loads: assert property (
		s_good_xfer |=> s_flag_raised
	) else $error("good transfer did not load result and flag");

	chk_cmp_false: assert property (
		state_r == adcs_pkg::ST_XFER && cmp_en && !cmp_ok && !abort && !flag_r
		|=> !flag_r && $stable(res_r)
	) else $error("failed compare changed result or flag");

	chk_block_drop: assert property (
		state_r == adcs_pkg::ST_XFER && blocked && !abort
		&& !(cmp_en && !cmp_ok && !ctrl_r[`ADCS_CTRL_CONT])
		|=> $stable(res_r) && state_r == adcs_pkg::ST_SAMPLE
	) else $error("blocked transfer not discarded");

	chk_irq_rise: assert property (
		$rose(flag_r) && ctrl_r[`ADCS_CTRL_IRQEN] |-> o_irq && $past(state_r == adcs_pkg::ST_XFER)
	) else $error("interrupt not raised with flag");

	chk_stop3_abort: assert property (
		stop_kill && !sw_start |=> state_r == adcs_pkg::ST_IDLE && $stable(res_r)
	) else $error("stop3 did not abort conversion");

	chk_hw_busy: assert property (
		state_r == adcs_pkg::ST_CONVERT && hw_edge && !abort && !cif.sar_done
		|=> state_r == adcs_pkg::ST_CONVERT
	) else $error("trigger edge disturbed running conversion");

	chk_async_warm: assert property (
		state_r == adcs_pkg::ST_WARM && cfg_r[1:0] == `ADCS_CLK_ASYNC
		|-> ##[1:260] state_r != adcs_pkg::ST_WARM
	) else $error("async oscillator start-up too long");
endmodule

//--- verification/adcs_analog_model.sv
`timescale 1ns/100ps
module adcs_analog_model (
	input  wire logic        i_clock,     // Bus clock
	input  wire logic        i_sample_en, // Sampling switch
	input  wire logic [11:0] i_trial,     // Trial code
	input  wire logic [11:0] i_level,     // Input level, half step added here
	output logic             o_above      // Held level above trial
);
	logic [11:0] held_r;
	always_ff @(posedge i_clock) begin
		if (i_sample_en) begin
			held_r <= i_level;
		end
	end
	// Isolated after sampling, half step avoids ties
	assign o_above = ({held_r, 1'h1} > {i_trial, 1'h0});
endmodule

//--- verification/adcs_seq_tb.sv
`timescale 1ns/100ps
`include "adcs_defines.svh"
module adcs_seq_tb;
	localparam logic [4:0] a_ctl = `ADCS_OFS_CTRL;
	localparam logic [4:0] a_trg = `ADCS_OFS_TRIG;
	localparam logic [4:0] a_cfg = `ADCS_OFS_CFG;
	localparam logic [4:0] a_rh  = `ADCS_OFS_RESH;
	localparam logic [4:0] a_rl  = `ADCS_OFS_RESL;
	localparam logic [4:0] a_ch  = `ADCS_OFS_CMPH;
	localparam logic [4:0] a_cl  = `ADCS_OFS_CMPL;
	logic        clk = 1'h0;
	logic        rst = 1'h1;
	logic [4:0]  adr = 5'h00;
	logic        rd = 1'h0;
	logic        wr = 1'h0;
	logic [31:0] wd = 32'h0;
	logic        hw = 1'h0;
	logic        wm = 1'h0;
	logic        s3 = 1'h0;
	logic        s12 = 1'h0;
	logic [11:0] lvl = 12'h000;
	logic        above;
	logic [31:0] rdq;
	logic        wreq, smp, irq, wake;
	logic [4:0]  chn;
	logic [11:0] trial;
	logic [7:0]  q, q2;
	int          fail_count = 0;
	int          cmp_count = 0;
	int          n, s;

	always #10 clk = ~clk;

	adcs_seq u_adcs_seq (
		.i_clock(clk), .i_rst(rst), .i_avs_address(adr), .i_avs_read(rd),
		.i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hF),
		.o_avs_readdata(rdq), .o_avs_waitrequest(wreq), .i_hardware_trigger_input(hw),
		.i_alt_tick(1'h0), .i_wait_mode(wm), .i_stop3_mode(s3), .i_stop12_mode(s12),
		.i_comp_above(above), .o_sample_en(smp), .o_channel(chn), .o_trial_code(trial),
		.o_irq(irq), .o_wake(wake)
	);
	adcs_analog_model u_adcs_analog_model (
		.i_clock(clk), .i_sample_en(smp), .i_trial(trial), .i_level(lvl), .o_above(above)
	);

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %s exp %0h got %0h", nm, exp, got);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// Request held until waitrequest seen low; settled values looked at mid-cycle
	task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
		int k;
		k = 0;
		adr <= a;
		wd <= {24'h000000, d};
		wr <= w;
		rd <= ~w;
		@(negedge clk);
		while (wreq !== 1'h0 && k < 20) begin
			@(negedge clk);
			k++;
		end
		chk("bus_wait", k < 20, 1'h1);
		@(posedge clk);
		q = rdq[7:0];
		wr <= 1'h0;
		rd <= 1'h0;
		@(posedge clk);
	endtask
	task automatic w8(input logic [4:0] a, input logic [7:0] d);
		bus(1'h1, a, d);
	endtask
	task automatic r8(input logic [4:0] a);
		bus(1'h0, a, 8'h00);
	endtask
	task automatic res(input logic [11:0] e);
		r8(a_rh);
		q2 = q;
		r8(a_rl);
		chk("result", {q2, q}, {4'h0, e});
	endtask
	// Count edges until the interrupt shows, and sampling cycles on the way
	task automatic conv(input int lim);
		n = 1;
		s = 0;
		@(negedge clk);
		while (irq !== 1'h1 && n < lim + 40) begin
			if (smp === 1'h1) s++;
			@(negedge clk);
			n++;
		end
		@(posedge clk);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_regs();
		logic [4:0] ad [7] = '{a_ctl, a_trg, a_cfg, a_rh, a_rl, a_ch, 5'h1C};
		chk("chan", chn, 5'h1F);
		for (int i = 0; i < 7; i++) begin
			r8(ad[i]);
			chk("reg", q, (i == 0) ? 8'h1F : 8'h00);
		end
		$display("test regs done");
	endtask
	task automatic t_single();
		logic [7:0] cf [6] = '{8'h04, 8'h08, 8'h00, 8'h10, 8'h14, 8'h05};
		logic [11:0] lv [6] = '{12'h9C3, 12'h9C0, 12'h5A0, 12'h5A0, 12'h3E7, 12'h6D5};
		logic [11:0] ex [6] = '{12'h9C3, 12'h270, 12'h05A, 12'h05A, 12'h3E7, 12'h6D5};
		int lm [6] = '{28, 28, 25, 45, 48, 51};
		int sp [6] = '{4, 4, 4, 24, 24, 8};
		wm <= 1'h1;
		for (int i = 0; i < 6; i++) begin
			lvl <= lv[i];
			w8(a_cfg, cf[i]);
			w8(a_ctl, 8'h43);
			conv(lm[i]);
			chk("latency", n <= lm[i], 1'h1);
			chk("sample", s, sp[i]);
			chk("irq", irq, 1'h1);
			chk("wake", wake, 1'h1);
			res(ex[i]);
			chk("irq_clr", irq, 1'h0);
		end
		wm <= 1'h0;
		$display("test single done");
	endtask
	task automatic t_cmp();
		logic [11:0] cv [3] = '{12'h7F0, 12'h801, 12'h801};
		logic [7:0] tg [3] = '{8'h30, 8'h30, 8'h20};
		logic [11:0] ex [3] = '{12'h010, 12'h010, 12'hFFF};
		lvl <= 12'h800;
		w8(a_cfg, 8'h04);
		for (int i = 0; i < 3; i++) begin
			w8(a_ch, {4'h0, cv[i][11:8]});
			w8(a_cl, cv[i][7:0]);
			w8(a_trg, tg[i]);
			w8(a_ctl, 8'h43);
			conv(28);
			chk("cmp_flag", irq, i != 1);
			res(ex[i]);
		end
		w8(a_trg, 8'h00);
		$display("test compare done");
	endtask
	task automatic t_cont();
		lvl <= 12'h7A1;
		w8(a_cfg, 8'h04);
		w8(a_ctl, 8'h63);
		conv(28);
		res(12'h7A1);
		conv(20);
		chk("next", n + 5 <= 20, 1'h1);
		r8(a_rh);
		lvl <= 12'h7B2;
		repeat (60) @(posedge clk);
		r8(a_rl);
		chk("blocked", q, 8'hA1);
		repeat (40) @(posedge clk);
		res(12'h7B2);
		w8(a_ctl, 8'h1F);
		$display("test continuous done");
	endtask
	task automatic t_stop3();
		lvl <= 12'h123;
		w8(a_ctl, 8'h43);
		repeat (5) @(posedge clk);
		s3 <= 1'h1;
		repeat (3) @(posedge clk);
		s3 <= 1'h0;
		repeat (40) @(posedge clk);
		chk("s3_irq", irq, 1'h0);
		r8(a_trg);
		chk("s3_idle", q[7], 1'h0);
		res(12'h7B2);
		w8(a_trg, 8'h40);
		w8(a_ctl, 8'h43);
		wm <= 1'h1;
		hw <= 1'h1;
		repeat (4) @(posedge clk);
		hw <= 1'h0;
		@(posedge clk);
		hw <= 1'h1;
		conv(22);
		chk("hw_irq", irq, 1'h1);
		chk("hw_wake", wake, 1'h1);
		res(12'h123);
		repeat (40) @(posedge clk);
		chk("hw_ign", irq, 1'h0);
		hw <= 1'h0;
		wm <= 1'h0;
		w8(a_trg, 8'h00);
		$display("test stop3 done");
	endtask
	task automatic t_async();
		r8(a_rl);
		lvl <= 12'hABC;
		w8(a_cfg, 8'h07);
		w8(a_ctl, 8'h43);
		s3 <= 1'h1;
		conv(301);
		chk("async_lat", n <= 301, 1'h1);
		chk("s3_wake", wake, 1'h1);
		s3 <= 1'h0;
		res(12'hABC);
		$display("test async done");
	endtask
	task automatic t_stop12();
		w8(a_cfg, 8'h14);
		w8(a_ctl, 8'h45);
		s12 <= 1'h1;
		repeat (2) @(posedge clk);
		s12 <= 1'h0;
		@(posedge clk);
		t_regs();
		$display("test stop12 done");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'h0;
		@(posedge clk);
		t_regs();
		t_single();
		t_cmp();
		t_cont();
		t_stop3();
		t_async();
		t_stop12();
		give_verdict();
	end
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		$display("BAD watchdog exp done got hang");
		give_verdict();
	end
endmodule
